// [txal_pkg.sv]
package txal_pkg;
  localparam int NUM_LANES        = 8;
  localparam int ALIGN_CYCLES     = 16;
  localparam int SKEW_BIT_CLOCKS  = 2;
  localparam int POSTDIV_W        = 3;
  localparam int WORDDIV_W        = 3;
  localparam int REFSEL_W         = 3;

  // Post-divider codes: 1, 2, 4, 8, 11
  localparam logic [2:0] PD_1  = 3'h0;
  localparam logic [2:0] PD_2  = 3'h1;
  localparam logic [2:0] PD_4  = 3'h2;
  localparam logic [2:0] PD_8  = 3'h3;
  localparam logic [2:0] PD_11 = 3'h4;

  // Word divider codes: 8,10,16,20,32,40,64,80
  localparam logic [2:0] WD_8  = 3'h0;
  localparam logic [2:0] WD_10 = 3'h1;
  localparam logic [2:0] WD_16 = 3'h2;
  localparam logic [2:0] WD_20 = 3'h3;
  localparam logic [2:0] WD_32 = 3'h4;
  localparam logic [2:0] WD_40 = 3'h5;
  localparam logic [2:0] WD_64 = 3'h6;
  localparam logic [2:0] WD_80 = 3'h7;

  // Reference clock sources
  localparam logic [2:0] REF_DIFF      = 3'h0;
  localparam logic [2:0] REF_SE0       = 3'h1;
  localparam logic [2:0] REF_SE1       = 3'h2;
  localparam logic [2:0] REF_CASCADE   = 3'h3;
  localparam logic [2:0] REF_RECOVERED = 3'h4;

  // Line rate in Mbps that exposes the fixed 125 MHz output
  localparam logic [15:0] RATE_2500 = 16'h09C4;
  localparam logic [7:0]  CLK125_DIV = 8'h01;

  function automatic logic [6:0] postdiv_val(input logic [2:0] c);
    case (c)
      PD_1:    postdiv_val = 7'h01;
      PD_2:    postdiv_val = 7'h02;
      PD_4:    postdiv_val = 7'h04;
      PD_8:    postdiv_val = 7'h08;
      PD_11:   postdiv_val = 7'h0B;
      default: postdiv_val = 7'h01;
    endcase
  endfunction

  function automatic logic [6:0] worddiv_val(input logic [2:0] c);
    case (c)
      WD_8:    worddiv_val = 7'h08;
      WD_10:   worddiv_val = 7'h0A;
      WD_16:   worddiv_val = 7'h10;
      WD_20:   worddiv_val = 7'h14;
      WD_32:   worddiv_val = 7'h20;
      WD_40:   worddiv_val = 7'h28;
      WD_64:   worddiv_val = 7'h40;
      default: worddiv_val = 7'h50;
    endcase
  endfunction
endpackage

// [txal_if.sv]
`timescale 1ns/10ps
interface txal_if #(parameter int N = 8);
  logic [N-1:0] lane_serializer_reset_n;
  logic [N-1:0] lane_serializer_reset_enable;
  logic         tx_align;
  logic         pll_lock;
  logic [N-1:0] lane_word_clk;
  logic [N-1:0] rx_word_clk;
  logic         clk_125;
  logic         fabric_refclk_out;

  modport device
  (
    input  lane_serializer_reset_n,
    input  lane_serializer_reset_enable,
    input  tx_align,
    output pll_lock,
    output lane_word_clk,
    output rx_word_clk,
    output clk_125,
    output fabric_refclk_out
  );

  modport fabric
  (
    output lane_serializer_reset_n,
    output lane_serializer_reset_enable,
    output tx_align,
    input  pll_lock,
    input  lane_word_clk,
    input  rx_word_clk,
    input  clk_125,
    input  fabric_refclk_out
  );
endinterface

// [txal_fabric.sv]
`timescale 1ns/10ps
module txal_fabric #(
  parameter int N = 8
)
(
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  txal_if.fabric            link,
  input  wire logic         start,
  input  wire logic         use_quad_reset,
  input  wire logic         divs_match,
  input  wire logic [N-1:0] lane_used,
  output logic              busy,
  output logic              aligned
);
  typedef enum logic [2:0] {F_IDLE, F_RESET, F_WAIT, F_PULSE, F_DONE} fst_t;
  typedef struct packed {
    fst_t         st;
    logic [4:0]   cnt;
    logic [N-1:0] rst_n;
    logic [N-1:0] rst_en;
    logic         align;
    logic         lock_q;
  } fab_t;

  fab_t r;
  fab_t next_r;

  always_comb
  begin
    next_r = r;
    next_r.lock_q = link.pll_lock;
    case (r.st)
      F_IDLE:
      begin
        if (start)
        begin
          next_r.rst_en = lane_used;
          if (!use_quad_reset)
          begin
            next_r.rst_n = ~lane_used;
            next_r.st = F_RESET;
          end
          else
            next_r.st = F_WAIT;
        end
      end
      F_RESET:
      begin
        next_r.rst_n = '1;
        next_r.st = F_WAIT;
      end
      F_WAIT:
      begin
        if (r.lock_q && divs_match)
        begin
          next_r.align = 1'b1;
          next_r.cnt = 5'h00;
          next_r.st = F_PULSE;
        end
      end
      F_PULSE:
      begin
        next_r.cnt = r.cnt + 5'h01;
        if (r.cnt == 5'(txal_pkg::ALIGN_CYCLES - 1))
        begin
          next_r.align = 1'b0;
          next_r.st = F_DONE;
        end
      end
      F_DONE:
      begin
        if (start)
          next_r.st = F_IDLE;
      end
      default: next_r.st = F_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      r.st     <= F_IDLE;
      r.cnt    <= 5'h00;
      r.rst_n  <= '1;
      r.rst_en <= '0;
      r.align  <= 1'b0;
      r.lock_q <= 1'b0;
    end
    else
      r <= next_r;
  end

  assign link.lane_serializer_reset_n      = r.rst_n;
  assign link.lane_serializer_reset_enable = r.rst_en;
  assign link.tx_align = r.align;
  assign busy    = (r.st != F_IDLE) && (r.st != F_DONE);
  assign aligned = (r.st == F_DONE);
endmodule

// [txal_device.sv]
`timescale 1ns/10ps
module txal_device #(
  parameter int N = 8,
  parameter int LOCK_CYCLES = 64,
  parameter int CDR_REF_CYCLES = 32
)
(
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  txal_if.device                    link,
  input  wire logic [2:0]           ref_sel,
  input  wire logic [4:0]           ref_present,
  input  wire logic [15:0]          line_rate_mbps,
  input  wire logic [N-1:0][2:0]    post_div,
  input  wire logic [N-1:0][2:0]    word_div,
  input  wire logic [N-1:0][2:0]    rx_word_div,
  input  wire logic                 lock_to_ref,
  input  wire logic [N-1:0]         rx_data_edge,
  input  wire logic                 global_by_refclk,
  output logic [N-1:0]              rx_locked_data,
  output logic [N-1:0]              lane_global_ok,
  output logic                      bit_clk
);
  typedef enum logic [1:0] {C_REF, C_DATA, C_LTR} cst_t;
  typedef struct packed {
    logic [7:0]            lock_cnt;
    logic                  lock;
    logic                  bit_clk;
    logic [N-1:0]          wclk;
    logic [N-1:0]          rclk;
    logic [N-1:0][6:0]     pcnt;
    logic [N-1:0][6:0]     wcnt;
    logic [N-1:0][6:0]     rcnt;
    logic [N-1:0][5:0]     cdr_cnt;
    logic [N-1:0][1:0]     cst;
    logic [N-1:0]          rlock;
    logic [6:0]            c125;
    logic                  clk125;
    logic                  refclk;
    logic                  glob_taken;
  } dev_t;

  dev_t r;
  dev_t next_r;
  logic ref_ok;
  logic rate_2500;
  logic [N-1:0] lane_rst;
  logic [6:0] pd;
  logic [6:0] wd;
  logic [6:0] rd;

  // Codes beyond the listed sources never lock
  always_comb
  begin
    ref_ok = 1'b0;
    case (ref_sel)
      txal_pkg::REF_DIFF,
      txal_pkg::REF_SE0,
      txal_pkg::REF_SE1,
      txal_pkg::REF_CASCADE,
      txal_pkg::REF_RECOVERED: ref_ok = ref_present[ref_sel];
      default:                 ref_ok = 1'b0;
    endcase
  end
  assign rate_2500 = (line_rate_mbps == txal_pkg::RATE_2500);
  assign lane_rst = ~link.lane_serializer_reset_n
                    & link.lane_serializer_reset_enable;

  always_comb
  begin
    next_r = r;
    pd = 7'h01;
    wd = 7'h08;
    rd = 7'h08;
    // Lock after a stable reference for LOCK_CYCLES
    if (!ref_ok)
    begin
      next_r.lock_cnt = 8'h00;
      next_r.lock = 1'b0;
    end
    else if (r.lock_cnt != 8'(LOCK_CYCLES))
      next_r.lock_cnt = r.lock_cnt + 8'h01;
    else
      next_r.lock = 1'b1;
    next_r.bit_clk = r.lock ? ~r.bit_clk : 1'b0;
    next_r.glob_taken = global_by_refclk;
    next_r.refclk = (ref_ok && r.glob_taken) ? ~r.refclk : 1'b0;
    for (int i = 0; i < N; i++)
    begin
      pd = txal_pkg::postdiv_val(post_div[i]);
      wd = txal_pkg::worddiv_val(word_div[i]);
      rd = txal_pkg::worddiv_val(rx_word_div[i]);
      if (lane_rst[i] || link.tx_align || !r.lock)
      begin
        next_r.pcnt[i] = 7'h00;
        next_r.wcnt[i] = 7'h00;
        next_r.wclk[i] = 1'b0;
      end
      else if (r.pcnt[i] >= pd - 7'h01)
      begin
        next_r.pcnt[i] = 7'h00;
        if (r.wcnt[i] >= (wd >> 1) - 7'h01)
        begin
          next_r.wcnt[i] = 7'h00;
          next_r.wclk[i] = ~r.wclk[i];
        end
        else
          next_r.wcnt[i] = r.wcnt[i] + 7'h01;
      end
      else
        next_r.pcnt[i] = r.pcnt[i] + 7'h01;
      // Receive clock recovery per lane
      case (r.cst[i])
        C_REF:
        begin
          if (lock_to_ref)
            next_r.cst[i] = C_LTR;
          else if (r.cdr_cnt[i] == 6'(CDR_REF_CYCLES) && ref_ok)
            next_r.cst[i] = C_DATA;
          else if (ref_ok)
            next_r.cdr_cnt[i] = r.cdr_cnt[i] + 6'h01;
          next_r.rlock[i] = 1'b0;
        end
        C_DATA:
        begin
          if (rx_data_edge[i])
            next_r.rlock[i] = 1'b1;
          if (!ref_ok || lock_to_ref)
          begin
            next_r.cst[i] = C_REF;
            next_r.cdr_cnt[i] = 6'h00;
          end
        end
        C_LTR:
        begin
          next_r.rlock[i] = 1'b0;
          if (!lock_to_ref || !ref_ok)
          begin
            next_r.cst[i] = C_REF;
            next_r.cdr_cnt[i] = 6'h00;
          end
        end
        default: next_r.cst[i] = C_REF;
      endcase
      if (r.cst[i] == C_REF)
      begin
        next_r.rcnt[i] = 7'h00;
        next_r.rclk[i] = 1'b0;
      end
      else if (r.rcnt[i] >= (rd >> 1) - 7'h01)
      begin
        next_r.rcnt[i] = 7'h00;
        next_r.rclk[i] = ~r.rclk[i];
      end
      else
        next_r.rcnt[i] = r.rcnt[i] + 7'h01;
    end
    // Fixed 125 MHz output, present only at 2500 Mbps
    if (r.lock && rate_2500)
    begin
      if (r.c125 >= 7'(txal_pkg::CLK125_DIV) - 7'h01)
      begin
        next_r.c125 = 7'h00;
        next_r.clk125 = ~r.clk125;
      end
      else
        next_r.c125 = r.c125 + 7'h01;
    end
    else
    begin
      next_r.c125 = 7'h00;
      next_r.clk125 = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      r <= '0;
    else
      r <= next_r;
  end

  assign link.pll_lock = r.lock;
  assign link.lane_word_clk = r.wclk;
  assign link.rx_word_clk = r.rclk;
  assign link.clk_125 = r.clk125;
  assign link.fabric_refclk_out = r.refclk;
  assign lane_global_ok = {N{~r.glob_taken}};
  assign rx_locked_data = r.rlock;
  assign bit_clk = r.bit_clk;
endmodule

// [txal_checker.sv]
`timescale 1ns/10ps
module txal_checker #(parameter int N = 8)
(
  input wire logic         sys_clk,
  input wire logic         nrst,
  input wire logic [N-1:0] lane_serializer_reset_n,
  input wire logic [N-1:0] lane_serializer_reset_enable,
  input wire logic         tx_align,
  input wire logic         pll_lock,
  input wire logic [N-1:0] lane_word_clk,
  input wire logic         clk_125
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Alignment pulse: two runs of eight, then low
  sequence hold8;
    tx_align [*8];
  endsequence
  sequence pulse16;
    hold8 ##1 hold8 ##1 !tx_align;
  endsequence

  align_len_a: assert property ($rose(tx_align) |-> pulse16)
    else $error("alignment pulse length wrong");
  align_lock_a: assert property (
    $rose(tx_align) |-> pll_lock && $past(pll_lock))
    else $error("alignment pulse before lock");
  rst_pulse_a: assert property (
    lane_serializer_reset_n != '1 |=> lane_serializer_reset_n == '1)
    else $error("lane reset longer than one cycle");
  rst_enable_a: assert property (
    (~lane_serializer_reset_n & ~lane_serializer_reset_enable) == '0)
    else $error("lane reset without enable");
  rst_quiet_a: assert property (
    tx_align |-> lane_serializer_reset_n == '1)
    else $error("lane reset during alignment");
  word_hold_a: assert property (
    tx_align |=> lane_word_clk == '0)
    else $error("word clock ran during alignment");
  clk125_lock_a: assert property (
    !pll_lock && !$past(pll_lock) |-> !clk_125)
    else $error("fixed clock without lock");
  clk125_rate_a: assert property (clk_125 |=> !clk_125)
    else $error("fixed clock not at half rate");
endmodule

// [tx_lane_align_and_clocking_tb_top.sv]
`timescale 1ns/10ps
module tx_lane_align_and_clocking_tb_top;
  localparam int N = 8;
  logic              sys_clk = 1'b0;
  logic              nrst = 1'b0;
  logic              start = 1'b0;
  logic              quad = 1'b0;
  logic              dm = 1'b1;
  logic [N-1:0]      used = 8'h1F;
  logic [2:0]        rsel = 3'h0;
  logic [4:0]        rpres = 5'h00;
  logic [15:0]       rate = 16'h0000;
  logic [N-1:0][2:0] pd = {N{txal_pkg::PD_1}};
  logic [N-1:0][2:0] wd = {N{txal_pkg::WD_8}};
  logic [N-1:0][2:0] rwd = {N{txal_pkg::WD_8}};
  logic              ltr = 1'b1;
  logic [N-1:0]      rxe = 8'h00;
  logic              gbr = 1'b0;
  logic              busy, aligned, bitc, v;
  logic [N-1:0]      rxl, gok;
  int                err_total = 0;
  int                checks_done = 0;

  txal_if #(.N(N)) link ();
  always #2 sys_clk = ~sys_clk;

  txal_fabric #(.N(N)) i_txal_fabric
  (
    .sys_clk(sys_clk), .nrst(nrst), .link(link), .start(start),
    .use_quad_reset(quad), .divs_match(dm), .lane_used(used),
    .busy(busy), .aligned(aligned)
  );
  txal_device #(.N(N), .LOCK_CYCLES(4), .CDR_REF_CYCLES(4)) i_txal_device
  (
    .sys_clk(sys_clk), .nrst(nrst), .link(link), .ref_sel(rsel),
    .ref_present(rpres), .line_rate_mbps(rate), .post_div(pd),
    .word_div(wd), .rx_word_div(rwd), .lock_to_ref(ltr),
    .rx_data_edge(rxe), .global_by_refclk(gbr), .rx_locked_data(rxl),
    .lane_global_ok(gok), .bit_clk(bitc)
  );
  txal_checker #(.N(N)) i_txal_checker
  (
    .sys_clk(sys_clk), .nrst(nrst),
    .lane_serializer_reset_n(link.lane_serializer_reset_n),
    .lane_serializer_reset_enable(link.lane_serializer_reset_enable),
    .tx_align(link.tx_align), .pll_lock(link.pll_lock),
    .lane_word_clk(link.lane_word_clk), .clk_125(link.clk_125)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic final_report;
    $display("mismatches=%0d checks=%0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Cycles until lane 0 transmit or receive word clock changes
  task automatic half(input logic rx, output int n);
    logic w;
    w = rx ? link.rx_word_clk[0] : link.lane_word_clk[0];
    n = 0;
    while ((rx ? link.rx_word_clk[0] : link.lane_word_clk[0]) === w
           && n < 200)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask

  task automatic t_lock;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge sys_clk);
      rsel <= i[2:0];
      rpres <= 5'h00;
      cyc(3);
      rpres <= 5'h1F;
      cyc(12);
      #1 check(link.pll_lock, i < 5);
    end
    @(posedge sys_clk);
    rsel <= txal_pkg::REF_DIFF;
    cyc(12);
    #1 check(link.pll_lock, 1'b1);
    v = bitc;
    cyc(1);
    #1 check(bitc, !v);
  endtask

  task automatic t_misc;
    logic f;
    @(posedge sys_clk);
    rate <= txal_pkg::RATE_2500;
    gbr <= 1'b1;
    rxe <= 8'hFF;
    cyc(12);
    #1 check(rxl, 8'h00);
    check(gok, 8'h00);
    v = link.clk_125;
    f = link.fabric_refclk_out;
    cyc(1);
    #1 check(link.clk_125, !v);
    check(link.fabric_refclk_out, !f);
    rate <= 16'h1388;
    gbr <= 1'b0;
    ltr <= 1'b0;
    cyc(12);
    #1 check(link.clk_125, 1'b0);
    check(link.fabric_refclk_out, 1'b0);
    check(gok, 8'hFF);
    check(rxl, 8'hFF);
  endtask

  task automatic t_seq(input logic [7:0] lanes, input logic q);
    int lo, al;
    logic [7:0] seen;
    lo = 0;
    al = 0;
    seen = 8'hFF;
    @(posedge sys_clk);
    used <= lanes;
    quad <= q;
    start <= 1'b1;
    for (int i = 0; i < 100; i++)
    begin
      @(posedge sys_clk);
      if (i == 1)
        start <= 1'b0;
      #1;
      if (aligned === 1'b1 && i > 2)
        break;
      if (link.lane_serializer_reset_n !== 8'hFF)
      begin
        lo++;
        seen = link.lane_serializer_reset_n;
        check(link.lane_serializer_reset_enable, lanes);
      end
      al += int'(link.tx_align);
    end
    check(lo, q ? 0 : 1);
    check(seen, q ? 8'hFF : 8'(~lanes));
    check(al, 16);
    check(aligned, 1'b1);
    repeat (20)
    begin
      check(link.lane_word_clk, {N{link.lane_word_clk[0]}});
      @(posedge sys_clk);
      #1;
    end
  endtask

  task automatic t_dm;
    @(posedge sys_clk);
    dm <= 1'b0;
    start <= 1'b1;
    cyc(2);
    start <= 1'b0;
    cyc(40);
    #1 check(link.tx_align, 1'b0);
    check(busy, 1'b1);
    @(posedge sys_clk);
    dm <= 1'b1;
    cyc(40);
    #1 check(aligned, 1'b1);
  endtask

  task automatic t_div;
    int n;
    int pdv[5] = '{1, 2, 4, 8, 11};
    int wdv[8] = '{8, 10, 16, 20, 32, 40, 64, 80};
    // Divider codes count up in table order
    for (int k = 0; k < 13; k++)
    begin
      @(posedge sys_clk);
      pd <= {N{(k < 5) ? k[2:0] : txal_pkg::PD_1}};
      wd <= {N{(k < 5) ? txal_pkg::WD_8 : 3'(k - 5)}};
      rwd <= {N{(k < 5) ? txal_pkg::WD_8 : 3'(k - 5)}};
      repeat (3) half(1'b0, n);
      if (k < 5)
        check(n, pdv[k] * 4);
      else
      begin
        check(n, wdv[k - 5] / 2);
        repeat (3) half(1'b1, n);
        check(n, wdv[k - 5] / 2);
      end
    end
  endtask

  initial
  begin
    #60000;
    err_total++;
    final_report;
  end

  initial
  begin
    cyc(20);
    nrst <= 1'b1;
    t_lock;
    t_misc;
    t_seq(8'h1F, 1'b0);
    t_seq(8'hFF, 1'b1);
    t_dm;
    t_div;
    final_report;
  end
endmodule
